/* File: rtl/mctmr_channel.sv */
`include "mctmr_params.svh"
module mctmr_channel #(
  parameter int W = `MCTMR_WIDTH,
  parameter int H = `MCTMR_HALF
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic soft_reset_in,
  input wire logic enable_in,
  input wire logic tick_in,
  input wire logic trig_in,
  input wire mctmr_pkg::mctmr_mode_t mode_in,
  input wire logic reload_on_trigger_in,
  input wire logic stop_on_timeout_in,
  input wire logic start_on_trigger_in,
  input wire logic [W-1:0] timer_reload_value_in,
  output logic [W-1:0] count_out,
  output logic [W-1:0] capture_out,
  output logic pre_trigger_out,
  output logic timeout_out
);
  import mctmr_pkg::*;
  mctmr_state_t state;
  mctmr_state_t next_state;
  logic [W-1:0] next_count;
  logic next_timeout;
  logic hit_zero;
  logic lo_zero;

  assign lo_zero = count_out[H-1:0] == `MCTMR_HALF_ZERO;
  assign hit_zero = count_out == `MCTMR_ZERO;

  always_comb begin
    next_state = state;
    next_count = count_out;
    next_timeout = 1'b0;
    if (!enable_in) begin
      next_state = MCTMR_IDLE;
    end else begin
      case (state)
        MCTMR_IDLE: begin
          // Trigger count mode always arms on first trigger
          if (start_on_trigger_in || mode_in == MCTMR_TRIGGER_COUNT_MODE) begin
            next_state = MCTMR_WAIT; // RULE15 RULE8
          end else begin
            next_state = MCTMR_RUN; // RULE6
            next_count = (mode_in == MCTMR_CAPTURE_MODE) ?
              `MCTMR_ALL_ONES : timer_reload_value_in; // RULE9
          end
        end
        MCTMR_WAIT: begin
          if (trig_in) begin
            next_state = MCTMR_RUN; // RULE15
            next_count = (mode_in == MCTMR_CAPTURE_MODE) ?
              `MCTMR_ALL_ONES : timer_reload_value_in;
          end
        end
        MCTMR_RUN: begin
          if (trig_in && reload_on_trigger_in &&
              mode_in != MCTMR_CAPTURE_MODE) begin
            next_count = timer_reload_value_in; // RULE13
          end else if (mode_in == MCTMR_TRIGGER_COUNT_MODE ? trig_in
                       : tick_in) begin // RULE8
            if (hit_zero) begin
              next_timeout = 1'b1; // RULE1 RULE6
              // Period reloads here, at start and on a reload trigger, so writes never restart
              next_count = (mode_in == MCTMR_CAPTURE_MODE) ?
                `MCTMR_ALL_ONES : timer_reload_value_in; // RULE2
              if (stop_on_timeout_in) begin
                next_state = MCTMR_STOP; // RULE14
                next_count = `MCTMR_ZERO;
              end
            end else if (mode_in == MCTMR_SPLIT_HALF_PERIODIC_MODE &&
                         !lo_zero) begin
              next_count[H-1:0] = count_out[H-1:0] - 1'b1; // RULE3
            end else if (mode_in == MCTMR_SPLIT_HALF_PERIODIC_MODE) begin
              next_count[W-1:H] = count_out[W-1:H] - 1'b1; // RULE3
            end else begin
              next_count = count_out - 1'b1; // RULE1 RULE7
            end
          end
        end
        MCTMR_STOP: begin
          // Held until enable drops, else a stop would restart at once
          next_state = MCTMR_STOP; // RULE14
        end
        default: next_state = MCTMR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= MCTMR_IDLE;
      count_out <= `MCTMR_ZERO;
      timeout_out <= 1'b0;
    end else if (soft_reset_in) begin
      state <= MCTMR_IDLE; // RULE18
      count_out <= `MCTMR_ZERO;
      timeout_out <= 1'b0;
    end else begin
      state <= next_state;
      count_out <= next_count; // RULE5
      timeout_out <= next_timeout;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      capture_out <= `MCTMR_ZERO;
    end else if (soft_reset_in) begin
      capture_out <= `MCTMR_ZERO;
    end else if (state == MCTMR_RUN && mode_in == MCTMR_CAPTURE_MODE &&
                 trig_in) begin
      capture_out <= ~count_out; // RULE9
    end
  end

  // Pre-trigger high from low half expiry until high half expiry
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pre_trigger_out <= 1'b0;
    end else if (soft_reset_in || state != MCTMR_RUN ||
                 mode_in != MCTMR_SPLIT_HALF_PERIODIC_MODE) begin
      pre_trigger_out <= 1'b0;
    end else if (next_timeout) begin
      pre_trigger_out <= 1'b0; // RULE3
    end else if (next_count[H-1:0] == `MCTMR_HALF_ZERO) begin
      pre_trigger_out <= 1'b1; // RULE3
    end
  end
endmodule

/* File: rtl/mctmr_params.svh */
// What this block does
// RULE1: Periodic count down, at zero flag and reload
// RULE2: New period applies only at next reload
// RULE3: Split halves: low half then high half
// RULE4: Software avoids period zero or one
// RULE5: Live count readable, zero to period
// RULE6: Start loads period; zero pulses trigger, flags
// RULE7: Full width mode uses all counter bits
// RULE8: Trigger count mode decrements per trigger
// RULE9: Capture mode stores inverse count on trigger
// RULE10: Per channel external or internal trigger
// RULE11: Trigger choice picks one of sixteen sources
// RULE12: Chained channel counts previous channel's timeouts
// RULE13: Reload on trigger when enabled; capture mode never reloads on a trigger
// RULE14: Stop on timeout when enabled
// RULE15: Start on trigger waits for a trigger
// RULE16: Debug setting halts or runs timers
// RULE17: Doze setting halts or runs timers
// RULE18: Soft reset clears all but module control
// RULE19: Software waits over four clocks after enable
// RULE20: Per channel flag and enable, mask access
// RULE21: Write one clears flag; irq on enabled flag
`ifndef MCTMR_PARAMS_SVH
`define MCTMR_PARAMS_SVH
`define MCTMR_CHANNELS 4
`define MCTMR_WIDTH 32
`define MCTMR_HALF 16
`define MCTMR_SEL_W 4
`define MCTMR_SOURCES 16
`define MCTMR_ALL_ONES 32'hFFFFFFFF
`define MCTMR_ZERO 32'h00000000
`define MCTMR_HALF_ZERO 16'h0000
`endif

/* File: rtl/mctmr_pkg.sv */
package mctmr_pkg;
  typedef enum logic [1:0] {
    MCTMR_FULL_WIDTH_PERIODIC_MODE = 2'b00,
    MCTMR_SPLIT_HALF_PERIODIC_MODE = 2'b01,
    MCTMR_TRIGGER_COUNT_MODE = 2'b10,
    MCTMR_CAPTURE_MODE = 2'b11
  } mctmr_mode_t;
  typedef enum logic [1:0] {
    MCTMR_IDLE = 2'b00,
    MCTMR_WAIT = 2'b01,
    MCTMR_RUN = 2'b10,
    MCTMR_STOP = 2'b11
  } mctmr_state_t;
endpackage

/* File: rtl/mctmr_top.sv */
`include "mctmr_params.svh"
module mctmr_top #(
  parameter int CH = `MCTMR_CHANNELS,
  parameter int W = `MCTMR_WIDTH,
  parameter int SW = `MCTMR_SEL_W
) (
  input wire logic REF_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic SOFT_RESET_IN,
  input wire logic DEBUG_IN,
  input wire logic DOZE_IN,
  input wire logic RUN_IN_DEBUG_IN,
  input wire logic RUN_IN_DOZE_IN,
  input wire logic [CH-1:0] CHANNEL_ENABLE_IN,
  input wire logic [CH*2-1:0] MODE_IN,
  input wire logic [CH-1:0] CHAIN_TO_PREVIOUS_IN,
  input wire logic [CH-1:0] RELOAD_ON_TRIGGER_IN,
  input wire logic [CH-1:0] STOP_ON_TIMEOUT_IN,
  input wire logic [CH-1:0] START_ON_TRIGGER_IN,
  input wire logic [CH-1:0] TRIGGER_ORIGIN_IN,
  input wire logic [CH*SW-1:0] TRIGGER_CHOICE_IN,
  input wire logic [(1<<SW)-1:0] EXT_TRIGGER_IN,
  input wire logic [CH*W-1:0] TIMER_RELOAD_VALUE_IN,
  input wire logic IRQ_ENABLE_SET_IN,
  input wire logic IRQ_ENABLE_CLEAR_IN,
  input wire logic [CH-1:0] IRQ_ENABLE_MASK_IN,
  input wire logic FLAG_CLEAR_IN,
  input wire logic [CH-1:0] FLAG_CLEAR_MASK_IN,
  output logic [CH*W-1:0] COUNT_OUT,
  output logic [CH*W-1:0] CAPTURE_OUT,
  output logic [CH-1:0] PRE_TRIGGER_OUT,
  output logic [CH-1:0] TRIGGER_PULSE_OUT,
  output logic [CH-1:0] TIMEOUT_FLAG_OUT,
  output logic [CH-1:0] IRQ_ENABLE_OUT,
  output logic IRQ_OUT
);
  import mctmr_pkg::*;
  logic run;
  logic [CH-1:0] timeout;
  logic [(1<<SW)-1:0] internal_src;
  logic [CH-1:0] enable_q;

  // Pick one source bit by trigger choice index
  function automatic logic pick(input logic [(1<<SW)-1:0] src,
                                input logic [SW-1:0] sel);
    pick = src[sel];
  endfunction

  assign run = (!DEBUG_IN || RUN_IN_DEBUG_IN) &&
               (!DOZE_IN || RUN_IN_DOZE_IN); // RULE16 RULE17

  // Channels beyond CH read as no trigger
  always_comb begin
    internal_src = '0;
    internal_src[CH-1:0] = timeout;
  end

  // Enable registered once; software still waits per RULE19
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      enable_q <= '0;
    end else begin
      enable_q <= CHANNEL_ENABLE_IN;
    end
  end

  genvar i;
  generate
    for (i = 0; i < CH; i++) begin : g_ch
      logic trig;
      logic tick;
      logic [SW-1:0] sel;
      assign sel = TRIGGER_CHOICE_IN[i*SW +: SW];
      assign trig = run && (TRIGGER_ORIGIN_IN[i] ?
                    pick(internal_src, sel) :
                    pick(EXT_TRIGGER_IN, sel)); // RULE10 RULE11
      if (i == 0) begin : g_first
        assign tick = run;
      end else begin : g_rest
        assign tick = run && (CHAIN_TO_PREVIOUS_IN[i] ?
                      timeout[i-1] : 1'b1); // RULE12
      end
      mctmr_channel #(.W(W)) u_ch (
        .clk_in(REF_CLK_IN),
        .arst_n_in(ARST_N_IN),
        .soft_reset_in(SOFT_RESET_IN),
        .enable_in(enable_q[i]),
        .tick_in(tick),
        .trig_in(trig),
        .mode_in(mctmr_mode_t'(MODE_IN[i*2 +: 2])),
        .reload_on_trigger_in(RELOAD_ON_TRIGGER_IN[i]),
        .stop_on_timeout_in(STOP_ON_TIMEOUT_IN[i]),
        .start_on_trigger_in(START_ON_TRIGGER_IN[i]),
        .timer_reload_value_in(TIMER_RELOAD_VALUE_IN[i*W +: W]),
        .count_out(COUNT_OUT[i*W +: W]),
        .capture_out(CAPTURE_OUT[i*W +: W]),
        .pre_trigger_out(PRE_TRIGGER_OUT[i]),
        .timeout_out(timeout[i])
      );
    end
  endgenerate

  assign TRIGGER_PULSE_OUT = timeout; // RULE6

  // Set wins over a same-cycle clear
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      TIMEOUT_FLAG_OUT <= '0;
    end else if (SOFT_RESET_IN) begin
      TIMEOUT_FLAG_OUT <= '0; // RULE18
    end else begin
      TIMEOUT_FLAG_OUT <= (TIMEOUT_FLAG_OUT &
        ~(FLAG_CLEAR_IN ? FLAG_CLEAR_MASK_IN : '0)) | timeout; // RULE20 RULE21
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      IRQ_ENABLE_OUT <= '0;
    end else if (SOFT_RESET_IN) begin
      IRQ_ENABLE_OUT <= '0; // RULE18
    end else if (IRQ_ENABLE_SET_IN) begin
      IRQ_ENABLE_OUT <= IRQ_ENABLE_OUT | IRQ_ENABLE_MASK_IN; // RULE20
    end else if (IRQ_ENABLE_CLEAR_IN) begin
      IRQ_ENABLE_OUT <= IRQ_ENABLE_OUT & ~IRQ_ENABLE_MASK_IN; // RULE20
    end
  end

  assign IRQ_OUT = |(TIMEOUT_FLAG_OUT & IRQ_ENABLE_OUT); // RULE21
endmodule

/* File: verif/mctmr_chk.sv */
module mctmr_chk #(
  parameter int CH = 4,
  parameter int W = 32
) (
  input wire logic REF_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic SOFT_RESET_IN,
  input wire logic DEBUG_IN,
  input wire logic RUN_IN_DEBUG_IN,
  input wire logic [CH-1:0] CHANNEL_ENABLE_IN,
  input wire logic IRQ_ENABLE_SET_IN,
  input wire logic IRQ_ENABLE_CLEAR_IN,
  input wire logic [CH-1:0] IRQ_ENABLE_MASK_IN,
  input wire logic FLAG_CLEAR_IN,
  input wire logic [CH-1:0] FLAG_CLEAR_MASK_IN,
  input wire logic [CH*W-1:0] COUNT_OUT,
  input wire logic [CH-1:0] PRE_TRIGGER_OUT,
  input wire logic [CH-1:0] TRIGGER_PULSE_OUT,
  input wire logic [CH-1:0] TIMEOUT_FLAG_OUT,
  input wire logic [CH-1:0] IRQ_ENABLE_OUT,
  input wire logic IRQ_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!ARST_N_IN || SOFT_RESET_IN);
  irq_level_a: assert property (IRQ_OUT == |(TIMEOUT_FLAG_OUT & IRQ_ENABLE_OUT))
    else $error("irq level wrong");
  flag_set_a: assert property (TRIGGER_PULSE_OUT[0] |=> TIMEOUT_FLAG_OUT[0])
    else $error("flag not set after timeout");
  flag_clear_a: assert property (FLAG_CLEAR_IN && FLAG_CLEAR_MASK_IN[0]
    && !TRIGGER_PULSE_OUT[0] |=> !TIMEOUT_FLAG_OUT[0]) else $error("flag kept");
  ien_set_a: assert property (IRQ_ENABLE_SET_IN && IRQ_ENABLE_MASK_IN[1]
    |=> IRQ_ENABLE_OUT[1]) else $error("enable not set");
  ien_clear_a: assert property (IRQ_ENABLE_CLEAR_IN && !IRQ_ENABLE_SET_IN
    && IRQ_ENABLE_MASK_IN[1] |=> !IRQ_ENABLE_OUT[1]) else $error("enable kept");
  pulse_at_zero_a: assert property (TRIGGER_PULSE_OUT[0]
    |-> $past(COUNT_OUT[W-1:0]) == '0) else $error("pulse without zero");
  pulse_single_a: assert property (TRIGGER_PULSE_OUT[0] |=> !TRIGGER_PULSE_OUT[0])
    else $error("pulse too long");
  debug_halt_a: assert property ((DEBUG_IN && !RUN_IN_DEBUG_IN
    && $stable(CHANNEL_ENABLE_IN))[*3] |=> $stable(COUNT_OUT)
    && TRIGGER_PULSE_OUT == '0) else $error("counting in debug halt");
  soft_reset_a: assert property (disable iff (!ARST_N_IN) SOFT_RESET_IN
    |=> TIMEOUT_FLAG_OUT == '0 && IRQ_ENABLE_OUT == '0 && COUNT_OUT == '0)
    else $error("soft reset left state");
  timeout_c: cover property (TRIGGER_PULSE_OUT[0]);
  irq_c: cover property (IRQ_OUT);
  pre_c: cover property (PRE_TRIGGER_OUT != '0);
endmodule

bind mctmr_top mctmr_chk #(.CH(CH), .W(W)) mctmr_chk_inst (
  .REF_CLK_IN(REF_CLK_IN), .ARST_N_IN(ARST_N_IN),
  .SOFT_RESET_IN(SOFT_RESET_IN), .DEBUG_IN(DEBUG_IN),
  .RUN_IN_DEBUG_IN(RUN_IN_DEBUG_IN), .CHANNEL_ENABLE_IN(CHANNEL_ENABLE_IN),
  .IRQ_ENABLE_SET_IN(IRQ_ENABLE_SET_IN),
  .IRQ_ENABLE_CLEAR_IN(IRQ_ENABLE_CLEAR_IN),
  .IRQ_ENABLE_MASK_IN(IRQ_ENABLE_MASK_IN), .FLAG_CLEAR_IN(FLAG_CLEAR_IN),
  .FLAG_CLEAR_MASK_IN(FLAG_CLEAR_MASK_IN), .COUNT_OUT(COUNT_OUT),
  .PRE_TRIGGER_OUT(PRE_TRIGGER_OUT), .TRIGGER_PULSE_OUT(TRIGGER_PULSE_OUT),
  .TIMEOUT_FLAG_OUT(TIMEOUT_FLAG_OUT), .IRQ_ENABLE_OUT(IRQ_ENABLE_OUT),
  .IRQ_OUT(IRQ_OUT));

/* File: verif/mctmr_top_bench.sv */
module mctmr_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, srst = 0, dbg = 0, doze = 0, rdbg = 0;
  logic rdoze = 0, ies = 0, iec = 0, fc = 0;
  logic [3:0] en = 0, chain = 0, rot = 0, sot = 0, sotr = 0, org = 0;
  logic [3:0] iem = 0, fcm = 0;
  logic [7:0] mode = 0;
  logic [15:0] tsel = 0, ext = 0;
  logic [127:0] rv = 0;
  logic [127:0] cnt_o, cap_o;
  logic [3:0] pre_o, pul_o, flg_o, ien_o;
  logic irq_o;
  logic [31:0] m_cnt [4], m_cap [4], m_ld;
  logic [1:0] m_st [4], m_old, m_md;
  logic [3:0] m_eq, m_pul, m_flg, m_ien, m_pre, m_trg, m_tck, m_sel;
  bit m_run;
  int bad_count = 0, compares = 0, cyc = 0;

  mctmr_top mctmr_top_inst (.REF_CLK_IN(clk), .ARST_N_IN(rst_n),
    .SOFT_RESET_IN(srst), .DEBUG_IN(dbg), .DOZE_IN(doze),
    .RUN_IN_DEBUG_IN(rdbg), .RUN_IN_DOZE_IN(rdoze), .CHANNEL_ENABLE_IN(en),
    .MODE_IN(mode), .CHAIN_TO_PREVIOUS_IN(chain), .RELOAD_ON_TRIGGER_IN(rot),
    .STOP_ON_TIMEOUT_IN(sot), .START_ON_TRIGGER_IN(sotr),
    .TRIGGER_ORIGIN_IN(org), .TRIGGER_CHOICE_IN(tsel), .EXT_TRIGGER_IN(ext),
    .TIMER_RELOAD_VALUE_IN(rv), .IRQ_ENABLE_SET_IN(ies),
    .IRQ_ENABLE_CLEAR_IN(iec), .IRQ_ENABLE_MASK_IN(iem),
    .FLAG_CLEAR_IN(fc), .FLAG_CLEAR_MASK_IN(fcm), .COUNT_OUT(cnt_o),
    .CAPTURE_OUT(cap_o), .PRE_TRIGGER_OUT(pre_o), .TRIGGER_PULSE_OUT(pul_o),
    .TIMEOUT_FLAG_OUT(flg_o), .IRQ_ENABLE_OUT(ien_o), .IRQ_OUT(irq_o));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic end_sim();
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  // Reference of all channels; states 0 idle, 1 wait, 2 run, 3 stop
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n || srst) begin
      {m_eq, m_pul, m_flg, m_ien, m_pre} = '0;
      for (int i = 0; i < 4; i++) begin
        m_cnt[i] = 0;
        m_cap[i] = 0;
        m_st[i] = 0;
      end
    end else begin
      m_run = !(dbg && !rdbg) && !(doze && !rdoze);
      // Triggers and ticks come from the pulses before this edge
      for (int i = 0; i < 4; i++) begin
        m_sel = tsel[i*4 +: 4];
        m_trg[i] = m_run && (org[i] ? (m_sel < 4 && m_pul[m_sel[1:0]])
                   : ext[m_sel]);
        m_tck[i] = m_run && !(i > 0 && chain[i] &&
                   !m_pul[(i + 3) % 4]);
      end
      m_flg = (m_flg & ~(fc ? fcm : 4'h0)) | m_pul;
      if (ies) m_ien = m_ien | iem;
      else if (iec) m_ien = m_ien & ~iem;
      for (int i = 0; i < 4; i++) begin
        m_md = mode[i*2 +: 2];
        m_ld = (m_md == 3) ? 32'hFFFFFFFF : rv[i*32 +: 32];
        m_old = m_st[i];
        if (m_old == 2 && m_md == 3 && m_trg[i]) m_cap[i] = ~m_cnt[i];
        m_pul[i] = 0;
        if (!m_eq[i]) m_st[i] = 0;
        else if (m_old == 0 && (sotr[i] || m_md == 2)) m_st[i] = 1;
        else if (m_old == 0 || (m_old == 1 && m_trg[i])) begin
          m_st[i] = 2;
          m_cnt[i] = m_ld;
        end else if (m_old == 2 && m_trg[i] && rot[i] && m_md != 3) begin
          m_cnt[i] = m_ld;
        end else if (m_old == 2 && (m_md == 2 ? m_trg[i] : m_tck[i])) begin
          if (m_cnt[i] == 0) begin
            // New period taken here, at start and on a reload trigger, never on a plain write
            m_pul[i] = 1;
            m_cnt[i] = sot[i] ? 32'h00000000 : m_ld;
            m_st[i] = sot[i] ? 2'h3 : 2'h2;
          end else if (m_md == 1 && m_cnt[i][15:0] == 0) begin
            m_cnt[i] -= 32'h00010000;
          end else m_cnt[i]--;
        end
        if (m_old != 2 || m_md != 1 || m_pul[i]) m_pre[i] = 0;
        else if (m_cnt[i][15:0] == 0) m_pre[i] = 1;
      end
      m_eq = en;
    end
  end

  always @(negedge clk) begin
    if (rst_n && !srst) begin
      for (int i = 0; i < 4; i++) begin
        chk(32'(flg_o[i]), 32'(m_flg[i]));
        chk(32'(ien_o[i]), 32'(m_ien[i]));
        chk(32'(pul_o[i]), 32'(m_pul[i]));
        chk(32'(pre_o[i]), 32'(m_pre[i]));
        chk(cap_o[i*32 +: 32], m_cap[i]);
        chk(cnt_o[i*32 +: 32], m_cnt[i]);
      end
      chk(32'(irq_o), 32'(|(m_flg & m_ien)));
    end
  end

  always @(posedge clk) begin
    ext <= #1 16'($urandom);
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(32'hD55DA142));
    mode = 8'hE4;
    {tsel, chain} = 20'($urandom);
    // Ch2 counts ch0 timeouts through the internal path
    tsel[11:8] = 4'h0;
    org = 4'h4;
    rot = 4'h8;
    sotr = 4'($urandom) & 4'h8;
    // No period of zero or one
    rv = {32'h00000009, 32'h00000005, 32'h00030006,
          32'(2 + $urandom % 7)};
    repeat (5) @(posedge clk);
    #1 rst_n = 1;
    en = 4'hF;
    {ies, iem} = 5'h1F;
    step(1);
    ies = 0;
    step(20);
    {fc, fcm} = 5'h1F;
    step(1);
    fc = 0;
    rv[31:0] = rv[31:0] + 32'h00000003;
    step(20);
    {ies, iec} = 2'h3;
    step(1);
    ies = 0;
    step(1);
    iec = 0;
    dbg = 1;
    step(6);
    rdbg = 1;
    step(4);
    {dbg, rdbg, doze} = 3'h1;
    step(6);
    {doze, sot[0]} = 2'h1;
    step(30);
    en[0] = 0;
    step(2);
    {en[0], sot[0]} = 2'h2;
    step(15);
    {en, srst} = 5'h01;
    step(2);
    {en, srst} = 5'h1E;
    step(15);
    repeat (200) begin
      {ies, iec, fc, iem, fcm} = 11'($urandom);
      rot[0] = 1'($urandom);
      step(1);
    end
    end_sim();
  end
endmodule
